// ==== sls_status_led.sv ====
/*
 * Status indicators and ambient light classification of a room transmitter.
 * Assumes a Modbus frame decoder on mclk_i hands over register accesses and
 * valid-frame pulses, and that measurement and alert inputs come from logic
 * on the same clock.
 */
// Overview of operation
// - green when value inside alert limits
// - steady yellow when value in alert range
// - yellow blinks on bus timeout unless red is lit, timeout nonzero
// - blinking stops once valid communication resumes
// - steady yellow alert beats timeout blinking
// - red at measurement range ends, CO2 alert2
// - red blinks when a sensor is lost
// - bootloader: green and yellow flash alternately
// - firmware download: red flashes as well
// - indicator source defaults CO2, selectable
// - brightness zero to full in tenths
// - illuminance readable in input register
// - master writes standby and active thresholds
// - below standby reports standby
// - above active reports active
// - between thresholds, either one included, reports low intensity
// - register enables bus termination resistor
// - one indicator lit right after reset
`timescale 1ns/1ps
`include "sls_cfg.svh"
module sls_status_led
    import sls_pkg::*;
#(
    parameter int unsigned CYC_PER_SEC = (`SLS_CLK_HZ / 1000) * `SLS_SECOND_MS,
    parameter int unsigned BLINK_CYC   = (`SLS_CLK_HZ / 1000) * `SLS_BLINK_HALF_MS
) (
    input  wire logic               mclk_i,                   // system clock
    input  wire logic               reset_i,                  // async reset, high
    input  wire logic               reg_space_i,              // 1 input regs, 0 holding
    input  wire logic [15:0]        reg_addr_i,               // register number
    input  wire logic               reg_wr_i,                 // write strobe
    input  wire logic               reg_rd_i,                 // read strobe
    input  wire logic [15:0]        reg_wdata_i,              // write data
    output logic      [15:0]        reg_rdata_o,              // read data
    output logic                    reg_ack_o,                // access done
    output logic                    reg_err_o,                // illegal address or write
    input  wire logic               frame_ok_i,               // valid frame seen
    input  wire logic [15:0]        co2_ppm_i,                // CO2 reading
    input  wire logic [15:0]        co2_alert1_i,             // CO2 alert 1 level
    input  wire logic [15:0]        co2_alert2_i,             // CO2 alert 2 level
    input  wire logic signed [15:0] temp_value_i,             // temperature
    input  wire logic signed [15:0] temp_alert_min_i,         // temp alert low limit
    input  wire logic signed [15:0] temp_alert_max_i,         // temp alert high limit
    input  wire logic signed [15:0] temp_range_min_i,         // temp range low end
    input  wire logic signed [15:0] temp_range_max_i,         // temp range high end
    input  wire logic [15:0]        rh_value_i,               // humidity
    input  wire logic [15:0]        rh_alert_min_i,           // rh alert low limit
    input  wire logic [15:0]        rh_alert_max_i,           // rh alert high limit
    input  wire logic [15:0]        rh_range_min_i,           // rh range low end
    input  wire logic [15:0]        rh_range_max_i,           // rh range high end
    input  wire logic [15:0]        lux_i,                    // illuminance in lux
    input  wire logic               sensor_lost_i,            // sensor contact lost
    input  wire logic               boot_mode_i,              // bootloader active
    input  wire logic               fw_download_i,            // firmware loading
    output logic                    led_green_o,              // green indicator
    output logic                    led_yellow_o,             // yellow indicator
    output logic                    led_red_o,                // red indicator
    output logic                    network_bus_terminator_o  // termination on
);
    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0] comm_timeout_setting;
    logic [15:0] bus_termination_enable;
    logic [15:0] light_active_threshold;
    logic [15:0] light_standby_threshold;
    logic [15:0] indicator_source_select;
    logic [15:0] indicator_brightness;
    logic [15:0] light_state_indication;
    logic [15:0] next_comm_timeout_setting;
    logic [15:0] next_bus_termination_enable;
    logic [15:0] next_light_active_threshold;
    logic [15:0] next_light_standby_threshold;
    logic [15:0] next_indicator_source_select;
    logic [15:0] next_indicator_brightness;
    logic [15:0] next_light_state_indication;
    logic [15:0] next_rdata;
    logic        next_ack;
    logic        next_err;
    logic        hit;

    always_comb begin
        next_comm_timeout_setting    = comm_timeout_setting;
        next_bus_termination_enable  = bus_termination_enable;
        next_light_active_threshold  = light_active_threshold;
        next_light_standby_threshold = light_standby_threshold;
        next_indicator_source_select = indicator_source_select;
        next_indicator_brightness    = indicator_brightness;
        next_rdata                   = reg_rdata_o;
        hit                          = 1'b1;
        if (reg_space_i) begin
            unique case (reg_addr_i)
                `SLS_OFS_LUX:         next_rdata = lux_i;
                `SLS_OFS_LIGHT_STATE: next_rdata = light_state_indication;
                default:              hit = 1'b0;
            endcase
            // input registers are read only
            if (reg_wr_i) begin
                hit = 1'b0;
            end
        end else begin
            unique case (reg_addr_i)
                `SLS_OFS_COMM_TIMEOUT:  next_rdata = comm_timeout_setting;
                `SLS_OFS_BUS_TERM:      next_rdata = bus_termination_enable;
                `SLS_OFS_LIGHT_ACTIVE:  next_rdata = light_active_threshold;
                `SLS_OFS_LIGHT_STANDBY: next_rdata = light_standby_threshold;
                `SLS_OFS_SOURCE_SEL:    next_rdata = indicator_source_select;
                `SLS_OFS_BRIGHTNESS:    next_rdata = indicator_brightness;
                default:                hit = 1'b0;
            endcase
            if (reg_wr_i) begin
                unique case (reg_addr_i)
                    `SLS_OFS_COMM_TIMEOUT:  next_comm_timeout_setting = reg_wdata_i;
                    `SLS_OFS_BUS_TERM:      next_bus_termination_enable = reg_wdata_i;
                    `SLS_OFS_LIGHT_ACTIVE:  next_light_active_threshold = reg_wdata_i;
                    `SLS_OFS_LIGHT_STANDBY: next_light_standby_threshold = reg_wdata_i;
                    `SLS_OFS_SOURCE_SEL:    next_indicator_source_select = reg_wdata_i;
                    `SLS_OFS_BRIGHTNESS:    next_indicator_brightness = reg_wdata_i;
                    default:                ;
                endcase
            end
        end
        if (!reg_rd_i) begin
            next_rdata = reg_rdata_o;
        end
        next_ack = (reg_wr_i || reg_rd_i) && hit;
        next_err = (reg_wr_i || reg_rd_i) && !hit;
        // equal to a threshold counts as low intensity
        if (lux_i < light_standby_threshold) begin
            next_light_state_indication = `SLS_LIGHT_STANDBY;
        end else if (lux_i > light_active_threshold) begin
            next_light_state_indication = `SLS_LIGHT_ACTIVE;
        end else begin
            next_light_state_indication = `SLS_LIGHT_LOW;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            comm_timeout_setting     <= `SLS_RST_COMM_TIMEOUT;
            bus_termination_enable   <= `SLS_RST_BUS_TERM;
            light_active_threshold   <= `SLS_RST_LIGHT_ACTIVE;
            light_standby_threshold  <= `SLS_RST_LIGHT_STANDBY;
            indicator_source_select  <= `SLS_RST_SOURCE_SEL;
            indicator_brightness     <= `SLS_RST_BRIGHTNESS;
            light_state_indication   <= `SLS_LIGHT_LOW;
            reg_rdata_o              <= 16'h0000;
            reg_ack_o                <= 1'b0;
            reg_err_o                <= 1'b0;
        end else begin
            comm_timeout_setting     <= next_comm_timeout_setting;
            bus_termination_enable   <= next_bus_termination_enable;
            light_active_threshold   <= next_light_active_threshold;
            light_standby_threshold  <= next_light_standby_threshold;
            indicator_source_select  <= next_indicator_source_select;
            indicator_brightness     <= next_indicator_brightness;
            light_state_indication   <= next_light_state_indication;
            reg_rdata_o              <= next_rdata;
            reg_ack_o                <= next_ack;
            reg_err_o                <= next_err;
        end
    end

    assign network_bus_terminator_o = bus_termination_enable[`SLS_BIT_TERM_EN];

    ////////////////////////////////////////////////////////////////////////////
    // communication timeout and blink timebase
    logic [23:0] sec_cnt;
    logic [23:0] next_sec_cnt;
    logic [15:0] idle_sec;
    logic [15:0] next_idle_sec;
    logic [23:0] blink_cnt;
    logic [23:0] next_blink_cnt;
    logic        blink_phase;
    logic        next_blink_phase;
    logic        comm_seen;
    logic        timed_out;

    always_comb begin
        // any register access is a valid frame as well
        comm_seen        = frame_ok_i || reg_wr_i || reg_rd_i;
        next_sec_cnt     = sec_cnt + 24'h00_0001;
        next_idle_sec    = idle_sec;
        if (sec_cnt == 24'(CYC_PER_SEC - 1)) begin
            next_sec_cnt  = 24'h00_0000;
            next_idle_sec = (idle_sec == 16'hFFFF) ? idle_sec : idle_sec + 16'h0001;
        end
        if (comm_seen) begin
            next_sec_cnt  = 24'h00_0000;
            next_idle_sec = 16'h0000;
        end
        next_blink_cnt   = blink_cnt + 24'h00_0001;
        next_blink_phase = blink_phase;
        if (blink_cnt == 24'(BLINK_CYC - 1)) begin
            next_blink_cnt   = 24'h00_0000;
            next_blink_phase = !blink_phase;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            sec_cnt     <= 24'h00_0000;
            idle_sec    <= 16'h0000;
            blink_cnt   <= 24'h00_0000;
            blink_phase <= 1'b0;
        end else begin
            sec_cnt     <= next_sec_cnt;
            idle_sec    <= next_idle_sec;
            blink_cnt   <= next_blink_cnt;
            blink_phase <= next_blink_phase;
        end
    end

    assign timed_out = (comm_timeout_setting != 16'h0000) && (idle_sec >= comm_timeout_setting);

    ////////////////////////////////////////////////////////////////////////////
    // classification of the selected quantity
    logic red_cond;
    logic yel_cond;
    logic grn_cond;

    always_comb begin
        unique case (indicator_source_select)
            `SLS_SRC_TEMP: begin
                red_cond = (temp_value_i <= temp_range_min_i) || (temp_value_i >= temp_range_max_i);
                grn_cond = (temp_value_i >= temp_alert_min_i) && (temp_value_i <= temp_alert_max_i);
            end
            `SLS_SRC_RH: begin
                red_cond = (rh_value_i <= rh_range_min_i) || (rh_value_i >= rh_range_max_i);
                grn_cond = (rh_value_i >= rh_alert_min_i) && (rh_value_i <= rh_alert_max_i);
            end
            default: begin
                // unknown selections fall back to CO2
                red_cond = (co2_ppm_i >= co2_alert2_i);
                grn_cond = (co2_ppm_i < co2_alert1_i);
            end
        endcase
        yel_cond = !red_cond && !grn_cond;
    end

    ////////////////////////////////////////////////////////////////////////////
    // display mode and indicator drive
    sls_mode_t  mode;
    sls_mode_t  next_mode;
    logic       lit_g;
    logic       lit_y;
    logic       lit_r;
    logic       next_lit_g;
    logic       next_lit_y;
    logic       next_lit_r;
    logic [3:0] dim_level;
    logic       dim_open;
    logic [15:0] bright_clip;

    always_comb begin
        if (boot_mode_i) begin
            next_mode = SLS_ST_BOOT;
        end else if (sensor_lost_i) begin
            next_mode = SLS_ST_SENS_LOST;
        end else if (timed_out) begin
            next_mode = SLS_ST_COMM_LOST;
        end else begin
            next_mode = SLS_ST_NORMAL;
        end
        next_lit_g = 1'b0;
        next_lit_y = 1'b0;
        next_lit_r = 1'b0;
        unique case (mode)
            SLS_ST_BOOT: begin
                next_lit_g = blink_phase;
                next_lit_y = !blink_phase;
                next_lit_r = fw_download_i && blink_phase;
            end
            SLS_ST_SENS_LOST: begin
                next_lit_r = blink_phase;
            end
            SLS_ST_COMM_LOST: begin
                next_lit_r = red_cond;
                next_lit_y = yel_cond || (!red_cond && blink_phase);
            end
            default: begin
                next_lit_r = red_cond;
                next_lit_y = yel_cond;
                next_lit_g = grn_cond && !red_cond;
            end
        endcase
        bright_clip = (indicator_brightness > `SLS_BRIGHT_MAX) ? `SLS_BRIGHT_MAX : indicator_brightness;
        dim_level   = 4'(bright_clip / `SLS_BRIGHT_STEP);
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            mode         <= SLS_ST_NORMAL;
            lit_g        <= 1'b0;
            lit_y        <= 1'b0;
            lit_r        <= 1'b0;
            led_green_o  <= 1'b0;
            led_yellow_o <= 1'b0;
            led_red_o    <= 1'b0;
        end else begin
            mode         <= next_mode;
            lit_g        <= next_lit_g;
            lit_y        <= next_lit_y;
            lit_r        <= next_lit_r;
            led_green_o  <= lit_g && dim_open;
            led_yellow_o <= lit_y && dim_open;
            led_red_o    <= lit_r && dim_open;
        end
    end

    sls_dimmer u_dimmer (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .level_i (dim_level),
        .open_o  (dim_open)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_term_write: assert property (@(posedge mclk_i) disable iff (reset_i)
        (reg_wr_i && !reg_space_i && reg_addr_i == `SLS_OFS_BUS_TERM)
        |=> network_bus_terminator_o == $past(reg_wdata_i[`SLS_BIT_TERM_EN]))
        else $error("termination does not follow its register");
    chk_standby_state: assert property (@(posedge mclk_i) disable iff (reset_i)
        (lux_i < light_standby_threshold) |=> light_state_indication == `SLS_LIGHT_STANDBY)
        else $error("standby not reported");
    chk_active_state: assert property (@(posedge mclk_i) disable iff (reset_i)
        (lux_i >= light_standby_threshold && lux_i > light_active_threshold)
        |=> light_state_indication == `SLS_LIGHT_ACTIVE)
        else $error("active not reported");
    chk_low_state: assert property (@(posedge mclk_i) disable iff (reset_i)
        (lux_i >= light_standby_threshold && lux_i <= light_active_threshold)
        |=> light_state_indication == `SLS_LIGHT_LOW)
        else $error("low intensity not reported");
    chk_boot_alternate: assert property (@(posedge mclk_i) disable iff (reset_i)
        boot_mode_i [*3] |-> lit_g != lit_y)
        else $error("boot flashing not alternating");
    chk_comm_restore: assert property (@(posedge mclk_i) disable iff (reset_i)
        frame_ok_i |-> ##2 mode != SLS_ST_COMM_LOST)
        else $error("timeout blinking after valid frame");
    chk_alert_steady: assert property (@(posedge mclk_i) disable iff (reset_i)
        (mode == SLS_ST_COMM_LOST && yel_cond) |=> lit_y)
        else $error("timeout blink hides yellow alert");
    chk_single_steady: assert property (@(posedge mclk_i) disable iff (reset_i)
        (mode == SLS_ST_NORMAL) |=> $onehot({lit_g, lit_y, lit_r}))
        else $error("normal mode not exactly one indicator");
    chk_sensor_red: assert property (@(posedge mclk_i) disable iff (reset_i)
        (mode == SLS_ST_SENS_LOST) |=> (!lit_g && !lit_y && lit_r == $past(blink_phase)))
        else $error("sensor loss not blinking red");
    chk_reg_answer: assert property (@(posedge mclk_i) disable iff (reset_i)
        (reg_wr_i || reg_rd_i) |=> (reg_ack_o != reg_err_o))
        else $error("register access unanswered");

    cov_boot_download: cover property (@(posedge mclk_i) disable iff (reset_i)
        mode == SLS_ST_BOOT && lit_r);
    cov_comm_blink: cover property (@(posedge mclk_i) disable iff (reset_i)
        mode == SLS_ST_COMM_LOST && !yel_cond && lit_y);
    cov_sensor_lost: cover property (@(posedge mclk_i) disable iff (reset_i)
        mode == SLS_ST_SENS_LOST && lit_r);
    cov_light_active: cover property (@(posedge mclk_i) disable iff (reset_i)
        light_state_indication == `SLS_LIGHT_ACTIVE);
endmodule : sls_status_led

// ==== sls_cfg.svh ====
/*
 * Constants of the status indicator and light level block: register offsets,
 * reset values, encodings and timing figures.
 * Assumes it is included by bare name by the package and the design modules.
 */
`ifndef SLS_CFG_SVH
`define SLS_CFG_SVH

// holding register offsets
`define SLS_OFS_COMM_TIMEOUT      16'h0008
`define SLS_OFS_BUS_TERM          16'h0009
`define SLS_OFS_LIGHT_ACTIVE      16'h0023
`define SLS_OFS_LIGHT_STANDBY     16'h0024
`define SLS_OFS_SOURCE_SEL        16'h004F
`define SLS_OFS_BRIGHTNESS        16'h0050
// input register offsets
`define SLS_OFS_LUX               16'h0029
`define SLS_OFS_LIGHT_STATE       16'h002A

// reset values
`define SLS_RST_COMM_TIMEOUT      16'h0000
`define SLS_RST_BUS_TERM          16'h0000
`define SLS_RST_LIGHT_ACTIVE      16'h01F4
`define SLS_RST_LIGHT_STANDBY     16'h0064
`define SLS_RST_SOURCE_SEL        16'h0000
`define SLS_RST_BRIGHTNESS        16'h0064

// field positions and encodings
`define SLS_BIT_TERM_EN           0
`define SLS_SRC_CO2               16'h0000
`define SLS_SRC_TEMP              16'h0001
`define SLS_SRC_RH                16'h0002
`define SLS_LIGHT_STANDBY         16'h0001
`define SLS_LIGHT_LOW             16'h0002
`define SLS_LIGHT_ACTIVE          16'h0003
`define SLS_BRIGHT_MAX            16'h0064
`define SLS_BRIGHT_STEP           16'h000A
`define SLS_DIM_STEPS             4'h9

// timing
`define SLS_CLK_HZ                10000000
`define SLS_SECOND_MS             1000
`define SLS_BLINK_HALF_MS         500
`define SLS_PWM_SLOT_US           10

`endif

// ==== sls_pkg.sv ====
/*
 * Types shared by the status indicator and light level block.
 * Assumes sls_cfg.svh is available on the include path.
 */
package sls_pkg;
    `include "sls_cfg.svh"

    // display mode, one-hot
    typedef enum logic [3:0] {
        SLS_ST_NORMAL    = 4'b0001,
        SLS_ST_COMM_LOST = 4'b0010,
        SLS_ST_SENS_LOST = 4'b0100,
        SLS_ST_BOOT      = 4'b1000
    } sls_mode_t;
endpackage : sls_pkg

// ==== sls_dimmer.sv ====
/*
 * Brightness gate: ten equal slots per period, the first level_i slots open.
 * Assumes level_i is 0..10 and comes from logic on mclk_i.
 */
`timescale 1ns/1ps
`include "sls_cfg.svh"
module sls_dimmer
    import sls_pkg::*;
#(
    parameter int unsigned SLOT_CYC = (`SLS_CLK_HZ / 1000000) * `SLS_PWM_SLOT_US
) (
    input  wire logic       mclk_i,   // system clock
    input  wire logic       reset_i,  // async reset, high
    input  wire logic [3:0] level_i,  // brightness in tenths
    output logic            open_o    // gate for the indicators
);
    logic [7:0] slot_cnt;
    logic [7:0] next_slot_cnt;
    logic [3:0] step;
    logic [3:0] next_step;
    logic       next_open;

    always_comb begin
        next_slot_cnt = slot_cnt + 8'h01;
        next_step     = step;
        if (slot_cnt == 8'(SLOT_CYC - 1)) begin
            next_slot_cnt = 8'h00;
            next_step     = (step == `SLS_DIM_STEPS) ? 4'h0 : step + 4'h1;
        end
        next_open = (next_step < level_i);
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            slot_cnt <= 8'h00;
            step     <= 4'h0;
            open_o   <= 1'b0;
        end else begin
            slot_cnt <= next_slot_cnt;
            step     <= next_step;
            open_o   <= next_open;
        end
    end

    chk_dim_full_on: assert property (@(posedge mclk_i) disable iff (reset_i)
        (level_i == 4'hA) [*2] |-> open_o)
        else $error("dimmer closed at full brightness");
    chk_dim_zero_off: assert property (@(posedge mclk_i) disable iff (reset_i)
        (level_i == 4'h0) [*2] |-> !open_o)
        else $error("dimmer open at zero brightness");
endmodule : sls_dimmer

// ==== sls_master_model.sv ====
/* Bus master model: drives decoded register accesses and frame pulses.
   Assumes answers come one edge after a strobe. */
`timescale 1ns/1ps
module sls_master_model (
    input  wire logic   mclk_i,   // system clock
    output logic        space_o,  // register space
    output logic [15:0] addr_o,   // register number
    output logic        wr_o,     // write strobe
    output logic        rd_o,     // read strobe
    output logic [15:0] wdata_o,  // write data
    output logic        frame_o   // valid frame
);
    initial {space_o, addr_o, wr_o, rd_o, wdata_o, frame_o} = '0;
    // idle bus shows inverted address and write data, not a stale copy
    task automatic access(input logic s, w, input logic [15:0] a, d);
        @(negedge mclk_i);
        {space_o, addr_o, wdata_o, wr_o, rd_o} = {s, a, d, w, !w};
        @(negedge mclk_i);
        {addr_o, wdata_o, wr_o, rd_o} = {~a, ~d, 2'b00};
    endtask : access
    task automatic frame();
        @(negedge mclk_i) frame_o = 1'b1;
        @(negedge mclk_i) frame_o = 1'b0;
    endtask : frame
endmodule : sls_master_model

// ==== sls_status_led_tb_top.sv ====
/* Self-checking bench of the status indicator block.
   Assumes the master model drives the register port. */
`timescale 1ns/1ps
module sls_status_led_tb_top;
    import sls_pkg::*;
    logic mclk_i = 0, reset_i = 1, sensor_lost_i = 0, boot_mode_i = 0, fw_download_i = 0;
    logic [15:0] co2_ppm_i = 16'h0190, co2_alert1_i = 16'h03E8, co2_alert2_i = 16'h07D0, lux_i = 0;
    logic [15:0] rh_value_i = 16'h0032, rh_alert_min_i = 16'h0014, rh_alert_max_i = 16'h0046;
    logic [15:0] rh_range_min_i = 0, rh_range_max_i = 16'h0064, reg_rdata_o, reg_addr_i, reg_wdata_i;
    logic signed [15:0] temp_value_i = 16'h0014, temp_alert_min_i = 16'h0010, temp_alert_max_i = 16'h0018;
    logic signed [15:0] temp_range_min_i = 0, temp_range_max_i = 16'h0032;
    logic reg_ack_o, reg_err_o, led_green_o, led_yellow_o, led_red_o, network_bus_terminator_o;
    logic reg_space_i, reg_wr_i, reg_rd_i, frame_ok_i;
    logic [2:0] o, a;
    logic [15:0] ofs[6] = '{16'h0008, 16'h0009, 16'h0023, 16'h0024, 16'h004F, 16'h0050};
    logic [15:0] rst[6] = '{16'h0000, 16'h0000, 16'h01F4, 16'h0064, 16'h0000, 16'h0064};
    logic [31:0] lfsr = 32'h8b3e_283e;
    int n_fail = 0, n_checks = 0, cyc = 0, sb = 100, ac = 500;
    sls_status_led #(.CYC_PER_SEC(20), .BLINK_CYC(8)) DUT (.mclk_i, .reset_i, .reg_space_i, .reg_addr_i,
        .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .reg_err_o, .frame_ok_i, .co2_ppm_i,
        .co2_alert1_i, .co2_alert2_i, .temp_value_i, .temp_alert_min_i, .temp_alert_max_i, .temp_range_min_i,
        .temp_range_max_i, .rh_value_i, .rh_alert_min_i, .rh_alert_max_i, .rh_range_min_i, .rh_range_max_i,
        .lux_i, .sensor_lost_i, .boot_mode_i, .fw_download_i, .led_green_o, .led_yellow_o, .led_red_o,
        .network_bus_terminator_o);
    sls_master_model m (.mclk_i, .space_o(reg_space_i), .addr_o(reg_addr_i), .wr_o(reg_wr_i),
        .rd_o(reg_rd_i), .wdata_o(reg_wdata_i), .frame_o(frame_ok_i));
    initial forever #50 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic chk(input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    task automatic acc(input logic s, w, e, input logic [15:0] ad, d, exp);
        // answer stands only until the edge after the strobe's edge
        m.access(s, w, ad, d);
        chk({reg_ack_o, reg_err_o}, {!e, e});
        if (!w && !e) chk(reg_rdata_o, exp);
    endtask : acc
    // or/and of each indicator over a window, long enough to span blink phases
    task automatic watch(input int n);
        {o, a} = {3'b000, 3'b111};
        repeat (4) @(posedge mclk_i);
        repeat (n) @(posedge mclk_i) #1 begin
            o |= {led_green_o, led_yellow_o, led_red_o};
            a &= {led_green_o, led_yellow_o, led_red_o};
        end
    endtask : watch
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (3) @(negedge mclk_i);
        reset_i = 0;
        watch(4);
        chk({o, a}, 6'b100_100);
        foreach (ofs[i]) acc(0, 0, 0, ofs[i], 0, rst[i]);
        acc(0, 0, 1, 16'h0007, 0, 0);
        acc(1, 1, 1, 16'h0029, 1, 0);
        acc(0, 1, 0, 16'h0009, 1, 0);
        chk(network_bus_terminator_o, 1);
        for (int i = 0; i < 12; i++) begin
            if (i == 6) {sb, ac} = {32'd336, 32'd592};
            if (i == 6) acc(0, 1, 0, 16'h0024, 16'h0150, 0);
            if (i == 6) acc(0, 1, 0, 16'h0023, 16'h0250, 0);
            lfsr = lfsr_next(lfsr);
            lux_i = (i % 6 == 0) ? 16'(sb) : (i % 6 == 1) ? 16'(ac) : {6'd0, lfsr[9:0]};
            acc(1, 0, 0, 16'h0029, 0, lux_i);
            acc(1, 0, 0, 16'h002A, 0, lux_i < sb ? 1 : lux_i > ac ? 3 : 2);
        end
        $display("test light done");
        co2_ppm_i = 16'h03E8;
        watch(4);
        chk({o, a}, 6'b010_010);
        {co2_ppm_i, co2_alert1_i} = {16'h07D0, 16'h0FA0};
        watch(4);
        chk({o, a}, 6'b001_001);
        acc(0, 1, 0, 16'h004F, 1, 0);
        watch(4);
        chk({o, a}, 6'b100_100);
        temp_value_i = temp_range_max_i;
        watch(4);
        chk({o, a}, 6'b001_001);
        acc(0, 1, 0, 16'h004F, 0, 0);
        {co2_ppm_i, co2_alert1_i} = {16'h0190, 16'h03E8};
        acc(0, 1, 0, 16'h0008, 1, 0);
        repeat (40) @(posedge mclk_i);
        watch(20);
        chk({o, a}, 6'b010_000);
        m.frame();
        watch(8);
        chk({o, a}, 6'b100_100);
        co2_ppm_i = 16'h0400;
        repeat (40) @(posedge mclk_i);
        watch(20);
        chk({o, a}, 6'b010_010);
        sensor_lost_i = 1;
        watch(20);
        chk({o, a}, 6'b001_000);
        {boot_mode_i, fw_download_i} = 2'b11;
        watch(20);
        chk({o, a}, 6'b111_000);
        chk(led_green_o ^ led_yellow_o, 1);
        fw_download_i = 0;
        watch(20);
        chk({o, a}, 6'b110_000);
        acc(0, 1, 0, 16'h0050, 0, 0);
        watch(20);
        chk(o, 3'b000);
        $display("test leds done");
        print_verdict();
    end
endmodule : sls_status_led_tb_top
